// ===== src/pmb_pkg.sv
package pmb_pkg;

   // Core clock and the times derived from it
   localparam int CLK_MHZ        = 50;
   localparam int SCL_TIMEOUT_US = 25000;
   localparam int SCL_TIMEOUT_CYC = SCL_TIMEOUT_US * CLK_MHZ;
   localparam int EE_PROG_US     = 5000;
   localparam int EE_PROG_CYC    = EE_PROG_US * CLK_MHZ;
   localparam int TO_W           = 21;
   localparam int PROG_W         = 18;

   // Fixed target addresses, 8-bit write form
   localparam logic [7:0] PMC_ADDR = 8'h20;
   localparam logic [7:0] EE_ADDR  = 8'hA0;

   // User memory geometry
   localparam int EE_DEPTH = 2048;
   localparam int EE_AW    = 11;

   // Byte and bit counting
   localparam logic [7:0] BLK_MAX   = 8'hFF;
   localparam logic [7:0] FILL_BYTE = 8'hFF;
   localparam logic [3:0] BIT_LAST  = 4'h8;
   localparam logic [3:0] BIT_ACK   = 4'h9;

   // Reset values of the pin and alert outputs
   localparam logic SDA_RELEASED = 1'b1;
   localparam logic ALERT_IDLE   = 1'b1;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_RX, ST_ACK_RX, ST_TX, ST_MACK
   } pmb_state_t;

   typedef enum logic [1:0] {TG_NONE, TG_PMC, TG_EE} pmb_target_t;

   // One received controller byte, a command, or the end of a write
   typedef struct packed {
      logic       valid;
      logic       is_cmd;
      logic       is_end;
      logic [7:0] data;
      logic [7:0] count;
   } pmb_evt_t;

   // Address match on the seven address bits
   function automatic logic pmb_addr_hit(input logic [7:0] b, input logic [7:0] a);
      return b[7:1] == a[7:1];
   endfunction : pmb_addr_hit

endpackage : pmb_pkg

// ===== src/pmb_link_sampler.sv
`timescale 1ns/100ps
// Captures data on each link clock rise and flags it with a toggle.
// The bit stays put for a whole link period, so the core may read it
// once the synchronised toggle has moved.
module pmb_link_sampler
   import pmb_pkg::*;
(
   input  wire logic link_scl_clk,
   input  wire logic rst_b,
   input  wire logic sda_in,
   output logic      bit_reg,
   output logic      tog_reg
);

   // Sample and announce
   always_ff @(posedge link_scl_clk or negedge rst_b) begin
      if (!rst_b) begin
         bit_reg <= 1'b0;
         tog_reg <= 1'b0;
      end else begin
         bit_reg <= sda_in;
         tog_reg <= ~tog_reg;
      end
   end

endmodule : pmb_link_sampler

// ===== src/pmb_slave.sv
`timescale 1ns/100ps
module pmb_slave
   import pmb_pkg::*;
#(
   parameter int SCL_TIMEOUT_CYC_P = SCL_TIMEOUT_CYC,
   parameter int EE_PROG_CYC_P     = EE_PROG_CYC
)(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       link_scl_clk,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   input  wire logic       eeprom_wp,
   input  wire logic [7:0] shutdown_evt,
   input  wire logic [7:0] warning_evt,
   output logic            fault_alert_out_n,
   output pmb_evt_t        pm_evt,
   output logic [7:0]      pm_cmd,
   output logic [7:0]      pm_rd_idx,
   output logic            pm_rd_active,
   input  wire logic [7:0] pm_rd_byte
);

   localparam logic [TO_W-1:0]   TO_LIM   = TO_W'(SCL_TIMEOUT_CYC_P - 1);
   localparam logic [PROG_W-1:0] PROG_LIM = PROG_W'(EE_PROG_CYC_P);

   logic              scl_meta, scl_s, scl_q;
   logic              sda_meta, sda_s, sda_q, sda_q2;
   logic              wp_meta, wp_s;
   logic              tog_meta, tog_s, tog_q;
   logic              link_bit, link_tog;
   logic              start, stop, scl_fall, bit_evt, to_hit, abort;
   logic [TO_W-1:0]   low_cnt_reg;
   logic [PROG_W-1:0] busy_cnt_reg;
   logic              ee_busy;
   pmb_state_t        state_reg;
   pmb_target_t       target_reg;
   logic              rw_reg, ee_wrote_reg, sda_oe_n_reg, alert_n_reg;
   logic [3:0]        bitcnt_reg;
   logic [7:0]        shift_reg, tx_reg, byte_cnt_reg, pm_cmd_reg;
   logic [EE_AW-1:0]  ptr_reg;
   logic [7:0]        mem [EE_DEPTH];
   logic [7:0]        tx_byte;
   logic              hit_pm, hit_ee, rx_ack, ee_wr_en, rx_done;
   pmb_evt_t          pm_evt_reg;

   // Link-side capture, run on the bus clock itself
   pmb_link_sampler u_sampler (
      .link_scl_clk (link_scl_clk),
      .rst_b        (rst_b),
      .sda_in       (sda_in),
      .bit_reg      (link_bit),
      .tog_reg      (link_tog)
   );

   // pin synchronisers
   // Oversampling 100 kbps at 50 MHz leaves ample margin for two stages
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {scl_meta, scl_s, scl_q}          <= 3'h7;
         {sda_meta, sda_s, sda_q, sda_q2}  <= 4'hF;
         {wp_meta, wp_s}                   <= 2'h3;
         {tog_meta, tog_s, tog_q}          <= 3'h0;
      end else begin
         {scl_meta, scl_s, scl_q}          <= {scl_in, scl_meta, scl_s};
         {sda_meta, sda_s, sda_q, sda_q2}  <= {sda_in, sda_meta, sda_s, sda_q};
         {wp_meta, wp_s}                   <= {eeprom_wp, wp_meta};
         {tog_meta, tog_s, tog_q}          <= {link_tog, tog_meta, tog_s};
      end
   end

   // bus conditions
   // Data is viewed one cycle later than clock, so a data change right
   // after a clock fall is never mistaken for a start or stop
   assign start    = scl_s & scl_q & sda_q2 & ~sda_q;
   assign stop     = scl_s & scl_q & ~sda_q2 & sda_q;
   assign scl_fall = scl_q & ~scl_s;
   assign bit_evt  = tog_s ^ tog_q;
   assign abort    = start | stop | to_hit;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         low_cnt_reg <= '0;
      end else if (scl_s) begin
         low_cnt_reg <= '0;
      end else if (low_cnt_reg != TO_LIM) begin
         low_cnt_reg <= low_cnt_reg + 1'b1;
      end
   end
   assign to_hit = ~scl_s & (low_cnt_reg == TO_LIM - 1'b1);

   // programming window after a memory write stop
   // The memory does not answer its address while programming
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_cnt_reg <= '0;
      end else if (stop & ee_wrote_reg) begin
         busy_cnt_reg <= PROG_LIM;
      end else if (busy_cnt_reg != '0) begin
         busy_cnt_reg <= busy_cnt_reg - 1'b1;
      end
   end
   assign ee_busy = busy_cnt_reg != '0;

   // address decode on the seven address bits
   assign hit_pm  = pmb_addr_hit(shift_reg, PMC_ADDR);
   assign hit_ee  = pmb_addr_hit(shift_reg, EE_ADDR) & ~ee_busy;
   assign rx_done = scl_fall & (state_reg == ST_RX) & (bitcnt_reg == BIT_LAST);

   // Acknowledge decision for a received byte
   always_comb begin
      rx_ack = 1'b1;
      if (target_reg == TG_EE && byte_cnt_reg != 8'h00) begin
         rx_ack = ~wp_s;
      end else if (target_reg == TG_PMC && byte_cnt_reg == BLK_MAX) begin
         rx_ack = 1'b0;
      end
   end
   assign ee_wr_en = rx_done & rx_ack & (target_reg == TG_EE) & (byte_cnt_reg != 8'h00);

   // byte to send next; controller reads fill once the block limit is met, memory reads never fill
   always_comb begin
      if (target_reg == TG_EE) begin
         tx_byte = mem[ptr_reg];
      end else if (byte_cnt_reg == BLK_MAX) begin
         tx_byte = FILL_BYTE;
      end else begin
         tx_byte = pm_rd_byte;
      end
   end

   // user memory, written when a data byte is accepted
   always_ff @(posedge clk) begin
      if (ee_wr_en) begin
         mem[ptr_reg] <= shift_reg;
      end
   end

   // Protocol engine
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg    <= ST_IDLE;
         target_reg   <= TG_NONE;
         rw_reg       <= 1'b0;
         ee_wrote_reg <= 1'b0;
         sda_oe_n_reg <= SDA_RELEASED;
         bitcnt_reg   <= '0;
         shift_reg    <= '0;
         tx_reg       <= '0;
         byte_cnt_reg <= '0;
         ptr_reg      <= '0;
         pm_cmd_reg   <= '0;
         pm_rd_active <= 1'b0;
         pm_evt_reg   <= '0;
      end else begin
         pm_evt_reg.valid <= 1'b0;
         if (abort) begin
            // every stop or timeout from a controller write of at least one byte to the next address byte gives an end event; a repeated start gives none
            if (!start && target_reg == TG_PMC && !rw_reg && byte_cnt_reg != 8'h00) begin
               pm_evt_reg <= '{valid: 1'b1, is_cmd: 1'b0, is_end: 1'b1, data: 8'h00, count: byte_cnt_reg};
            end
            // drop the partial transfer and release the bus
            state_reg    <= start ? ST_ADDR : ST_IDLE;
            bitcnt_reg   <= '0;
            sda_oe_n_reg <= SDA_RELEASED;
            ee_wrote_reg <= 1'b0;
            pm_rd_active <= 1'b0;
         end else if (bit_evt) begin
            bitcnt_reg <= bitcnt_reg + 1'b1;
            shift_reg  <= {shift_reg[6:0], link_bit};
            // A host NACK ends the read; wait for stop or start
            if (state_reg == ST_MACK && link_bit) begin
               state_reg    <= ST_IDLE;
               pm_rd_active <= 1'b0;
            end
         end else if (scl_fall) begin
            unique case (state_reg)
               ST_IDLE: begin
               end
               ST_ADDR: begin
                  if (bitcnt_reg == BIT_LAST) begin
                     rw_reg       <= shift_reg[0];
                     byte_cnt_reg <= '0;
                     if (hit_pm || hit_ee) begin
                        target_reg   <= hit_pm ? TG_PMC : TG_EE;
                        sda_oe_n_reg <= 1'b0;
                        state_reg    <= ST_ACK_ADDR;
                     end else begin
                        target_reg <= TG_NONE;
                        state_reg  <= ST_IDLE;
                     end
                  end
               end
               ST_ACK_ADDR: begin
                  bitcnt_reg <= '0;
                  if (rw_reg) begin
                     tx_reg       <= tx_byte;
                     sda_oe_n_reg <= tx_byte[7];
                     state_reg    <= ST_TX;
                     pm_rd_active <= target_reg == TG_PMC;
                     byte_cnt_reg <= byte_cnt_reg + 1'b1;
                     ptr_reg      <= ptr_reg + 1'b1;
                  end else begin
                     sda_oe_n_reg <= SDA_RELEASED;
                     state_reg    <= ST_RX;
                  end
               end
               ST_RX: begin
                  if (bitcnt_reg == BIT_LAST) begin
                     sda_oe_n_reg <= ~rx_ack;
                     state_reg    <= rx_ack ? ST_ACK_RX : ST_IDLE;
                     if (rx_ack) begin
                        byte_cnt_reg <= byte_cnt_reg + 1'b1;
                     end
                     // first byte sets the memory offset
                     if (target_reg == TG_EE) begin
                        if (byte_cnt_reg == 8'h00) begin
                           ptr_reg <= {{(EE_AW - 8){1'b0}}, shift_reg};
                        end else if (rx_ack) begin
                           ptr_reg      <= ptr_reg + 1'b1;
                           ee_wrote_reg <= 1'b1;
                        end
                     // first byte is a command code
                     end else if (rx_ack) begin
                        if (byte_cnt_reg == 8'h00) begin
                           pm_cmd_reg <= shift_reg;
                        end
                        pm_evt_reg <= '{valid: 1'b1, is_cmd: byte_cnt_reg == 8'h00, is_end: 1'b0,
                                        data: shift_reg, count: byte_cnt_reg};
                     end
                  end
               end
               ST_ACK_RX: begin
                  sda_oe_n_reg <= SDA_RELEASED;
                  bitcnt_reg   <= '0;
                  state_reg    <= ST_RX;
               end
               ST_TX: begin
                  if (bitcnt_reg == BIT_LAST) begin
                     sda_oe_n_reg <= SDA_RELEASED;
                     state_reg    <= ST_MACK;
                  end else begin
                     sda_oe_n_reg <= tx_reg[3'(4'h7 - bitcnt_reg)];
                  end
               end
               ST_MACK: begin
                  // next byte of a block read after a host ACK
                  if (bitcnt_reg == BIT_ACK) begin
                     tx_reg       <= tx_byte;
                     sda_oe_n_reg <= tx_byte[7];
                     bitcnt_reg   <= '0;
                     state_reg    <= ST_TX;
                     if (byte_cnt_reg != BLK_MAX) begin
                        byte_cnt_reg <= byte_cnt_reg + 1'b1;
                     end
                     ptr_reg <= ptr_reg + 1'b1;
                  end
               end
               default: begin
                  state_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // alert is the OR of both event groups
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         alert_n_reg <= ALERT_IDLE;
      end else begin
         alert_n_reg <= ~((|shutdown_evt) | (|warning_evt));
      end
   end

   // open drain on data only; the clock pin is never driven
   // so no stretch can occur at all
   assign sda_out           = 1'b0;
   assign sda_oe_n          = sda_oe_n_reg;
   assign fault_alert_out_n = alert_n_reg;
   assign pm_evt            = pm_evt_reg;
   assign pm_cmd            = pm_cmd_reg;
   assign pm_rd_idx         = byte_cnt_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   chk_alert_on_event: assert property (
      (|shutdown_evt || |warning_evt) |=> !fault_alert_out_n) else $error("alert not raised");
   chk_alert_quiet: assert property (
      !(|shutdown_evt || |warning_evt) |=> fault_alert_out_n) else $error("alert raised with no event");
   chk_timeout_release: assert property (
      to_hit |=> sda_oe_n && state_reg == ST_IDLE) else $error("timeout did not release");
   chk_start_resync: assert property (
      start |=> state_reg == ST_ADDR && bitcnt_reg == 4'h0 && sda_oe_n) else $error("start not resynced");
   chk_stop_idle: assert property (
      stop |=> state_reg == ST_IDLE && sda_oe_n) else $error("stop left bus held");
   chk_foreign_nack: assert property (
      scl_fall && !abort && state_reg == ST_ADDR && bitcnt_reg == BIT_LAST && !hit_pm && !hit_ee
      |=> sda_oe_n [*3]) else $error("foreign address acknowledged");
   chk_pmc_addr_ack: assert property (
      scl_fall && !abort && state_reg == ST_ADDR && bitcnt_reg == BIT_LAST && hit_pm
      |=> !sda_oe_n && target_reg == TG_PMC) else $error("controller address not acknowledged");
   chk_wp_refuse: assert property (
      rx_done && !abort && target_reg == TG_EE && byte_cnt_reg != 8'h00 && wp_s
      |=> sda_oe_n && $stable(ptr_reg)) else $error("protected write accepted");
   chk_block_limit: assert property (
      rx_done && !abort && target_reg == TG_PMC && byte_cnt_reg == BLK_MAX
      |=> sda_oe_n && !pm_evt.valid) else $error("byte beyond block limit accepted");
   chk_cmd_capture: assert property (
      pm_evt.valid && pm_evt.is_cmd |-> pm_cmd == pm_evt.data && pm_evt.count == 8'h00)
      else $error("command byte not captured");

endmodule : pmb_slave

// ===== testbench/pmb_host_model.sv
`timescale 1ns/100ps
// Bus master on the far side of the link; data open drain and released when idle, clock driven directly
module pmb_host_model #(
   parameter int HALF_NS = 5000
)(
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   // Idle bus: clock stands high, data released to the pull-up
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // One bit cell, 10 us per bit
   // Data moves an eighth of a cell after the clock fall, so no false start or stop is seen
   task automatic clk_bit(input logic b, output logic s);
      #(HALF_NS / 4) sda_low = ~b;
      #(HALF_NS * 3 / 4) scl = 1'b1;
      #(HALF_NS / 2) s = sda;
      #(HALF_NS / 2) scl = 1'b0;
   endtask : clk_bit

   // Start from idle or repeated start from mid-frame
   task automatic start();
      #(HALF_NS / 4) sda_low = 1'b0;
      #(HALF_NS * 3 / 4) scl = 1'b1;
      #(HALF_NS) sda_low = 1'b1;
      #(HALF_NS) scl = 1'b0;
   endtask : start

   // Stop, then the bus is left idle
   task automatic stop();
      #(HALF_NS / 4) sda_low = 1'b1;
      #(HALF_NS * 3 / 4) scl = 1'b1;
      #(HALF_NS) sda_low = 1'b0;
      #(HALF_NS);
   endtask : stop

   // Bytes go MSB first, target answers in the ninth cell
   task automatic send(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], s);
      end
      clk_bit(1'b1, s);
      ack = ~s;
   endtask : send

   // One byte is read per call; ack asks for one more
   task automatic recv(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, s);
         d[i] = s;
      end
      clk_bit(~ack, s);
   endtask : recv
endmodule : pmb_host_model

// ===== testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
   import pmb_pkg::*;
   localparam int TO_P   = 1000;  // Above the 250-cycle low half of a bit cell
   localparam int PROG_P = 2000;
   logic       clk, rst_b, eeprom_wp, sda_oe_n, fault_alert_out_n, pm_rd_active, sda_w, ack, host_scl, host_low;
   logic [7:0] shutdown_evt, warning_evt, pm_cmd, pm_rd_idx, pm_rd_byte, end_cnt, cmd_seen, d, dat_seen, dat_idx;
   logic       sda_drv;
   pmb_evt_t   pm_evt;
   int         n_fail = 0;
   int         cmp_count = 0;

   // Open-drain data wire with pull-up; the device's driven level only counts while enabled
   assign sda_w = ~host_low & (sda_oe_n | sda_drv);

   pmb_host_model host (.scl(host_scl), .sda_low(host_low), .sda(sda_w));

   pmb_slave #(.SCL_TIMEOUT_CYC_P(TO_P), .EE_PROG_CYC_P(PROG_P)) DUT (
      .clk(clk), .rst_b(rst_b), .link_scl_clk(host_scl), .scl_in(host_scl), .sda_in(sda_w),
      .sda_out(sda_drv), .sda_oe_n(sda_oe_n), .eeprom_wp(eeprom_wp), .shutdown_evt(shutdown_evt),
      .warning_evt(warning_evt), .fault_alert_out_n(fault_alert_out_n), .pm_evt(pm_evt),
      .pm_cmd(pm_cmd), .pm_rd_idx(pm_rd_idx), .pm_rd_active(pm_rd_active), .pm_rd_byte(pm_rd_byte));

   initial clk = 1'b0;
   always #10 clk = ~clk;

   // Read data follows the index; lags a cycle, well before the next clock fall
   always @(posedge clk) pm_rd_byte <= 8'hC0 + pm_rd_idx;

   // Remember the last command and end-of-write count
   always @(posedge clk) begin
      if (pm_evt.valid === 1'b1 && pm_evt.is_end === 1'b1) end_cnt <= pm_evt.count;
      if (pm_evt.valid === 1'b1 && pm_evt.is_cmd === 1'b1) cmd_seen <= pm_evt.data;
      // Last data byte of a controller write and its position
      if (pm_evt.valid === 1'b1 && pm_evt.is_cmd === 1'b0 && pm_evt.is_end === 1'b0) begin
         dat_seen <= pm_evt.data;
         dat_idx  <= pm_evt.count;
      end
   end

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic tx(input logic [7:0] b, input logic exp);
      host.send(b, ack);
      chk("ack", {7'h00, exp}, {7'h00, ack});
   endtask : tx

   task automatic t_unmatched();
      host.start();
      tx(8'h50, 1'b0);
      host.stop();
      $display("test unmatched done");
   endtask : t_unmatched

   // Memory write then wait out the programming time
   task automatic t_ee_write(input logic [7:0] off, input logic [7:0] v, input logic wp);
      @(posedge clk) eeprom_wp <= wp;
      host.start();
      tx(EE_ADDR, 1'b1);
      tx(off, 1'b1);
      tx(v, ~wp);
      host.stop();
      repeat (PROG_P + 100) @(posedge clk);
      $display("test memory write done");
   endtask : t_ee_write

   task automatic t_ee_read(input logic [7:0] off, input logic [7:0] exp);
      host.start();
      tx(EE_ADDR, 1'b1);
      tx(off, 1'b1);
      host.start();
      tx(EE_ADDR | 8'h01, 1'b1);
      host.recv(1'b0, d);
      host.stop();
      chk("memory byte", exp, d);
      $display("test memory read done");
   endtask : t_ee_read

   task automatic t_pmc_word();
      host.start();
      tx(PMC_ADDR, 1'b1);
      tx(8'h3B, 1'b1);
      tx(8'h11, 1'b1);
      tx(8'h22, 1'b1);
      host.stop();
      repeat (10) @(posedge clk);
      chk("command", 8'h3B, cmd_seen);
      chk("last data", 8'h22, dat_seen);
      chk("last data index", 8'h02, dat_idx);
      chk("end count", 8'h03, end_cnt);
      chk("pm_cmd", 8'h3B, pm_cmd);
      $display("test controller word write done");
   endtask : t_pmc_word

   task automatic t_pmc_read();
      host.start();
      tx(PMC_ADDR, 1'b1);
      tx(8'h8B, 1'b1);
      host.start();
      tx(PMC_ADDR | 8'h01, 1'b1);
      host.recv(1'b1, d);
      chk("read byte 0", 8'hC0, d);
      // Let the device take the host ACK, then it asks for the third byte
      repeat (10) @(posedge clk);
      chk("read active high", 8'h01, {7'h00, pm_rd_active});
      chk("read index", 8'h02, pm_rd_idx);
      host.recv(1'b0, d);
      chk("read byte 1", 8'hC1, d);
      host.stop();
      chk("read active", 8'h00, {7'h00, pm_rd_active});
      $display("test controller read done");
   endtask : t_pmc_read

   // Clock held low while the device drives its ack, then a mid-byte restart
   task automatic t_timeout();
      host.start();
      tx(PMC_ADDR, 1'b1);
      for (int i = 7; i >= 0; i--) host.clk_bit(i[0], ack);
      repeat (50) @(posedge clk);
      chk("ack held", 8'h00, {7'h00, sda_oe_n});
      repeat (TO_P + 10) @(posedge clk);
      chk("released", 8'h01, {7'h00, sda_oe_n});
      chk("timeout end count", 8'h01, end_cnt);
      host.stop();
      host.start();
      for (int i = 0; i < 3; i++) host.clk_bit(1'b0, ack);
      host.start();
      tx(EE_ADDR, 1'b1);
      host.stop();
      $display("test timeout and abort done");
   endtask : t_timeout

   task automatic t_alert();
      @(posedge clk) shutdown_evt <= 8'h04;
      repeat (3) @(posedge clk);
      chk("alert shutdown", 8'h00, {7'h00, fault_alert_out_n});
      shutdown_evt <= 8'h00;
      warning_evt  <= 8'h80;
      repeat (3) @(posedge clk);
      chk("alert warning", 8'h00, {7'h00, fault_alert_out_n});
      warning_evt <= 8'h00;
      repeat (3) @(posedge clk);
      chk("alert idle", 8'h01, {7'h00, fault_alert_out_n});
      $display("test alert done");
   endtask : t_alert

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   initial begin
      rst_b = 1'b0;
      eeprom_wp = 1'b0;
      shutdown_evt = 8'h00;
      warning_evt = 8'h00;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
      t_alert();
      t_unmatched();
      t_ee_write(8'h10, 8'h5A, 1'b0);
      // Protected write second, so the read proves both the store and the refusal
      t_ee_write(8'h10, 8'hA5, 1'b1);
      t_ee_read(8'h10, 8'h5A);
      t_pmc_word();
      t_pmc_read();
      t_timeout();
      end_of_test();
   end

   // Watchdog above the expected run of about 2.5 ms
   initial begin
      #3_000_000;
      n_fail++;
      end_of_test();
   end
endmodule : testbench
